// [logic/rfs_map.vh]
// constants for the regulator fault supervisor: offsets, fields, timing
// assumes a single pclk domain at the rate given below
`ifndef RFS_MAP_VH
`define RFS_MAP_VH
// ======================================================================
// timing
`define RFS_CLK_MHZ        200
`define RFS_UV_TIME_US     1000
`define RFS_UV_CYCLES      (`RFS_UV_TIME_US * `RFS_CLK_MHZ)
`define RFS_UV_CNT_W       18
// ======================================================================
// thresholds, millivolt and microamp codes
`define RFS_UV_MARGIN_MV   295
`define RFS_SOV_TRIP_MV    1800
`define RFS_SOV_REL_MV     850
`define RFS_OC_GAIN        5
`define RFS_OC_DIV         6
`define RFS_BR_SRC_UA      10
// ======================================================================
// register offsets
`define RFS_A_CTRL         8'h00
`define RFS_A_STATUS       8'h04
`define RFS_A_INT_STAT     8'h08
`define RFS_A_INT_EN       8'h0c
`define RFS_A_INT_CLR      8'h10
// ======================================================================
// fields
`define RFS_CTRL_EN        0
`define RFS_CTRL_RST       1'h1
`define RFS_EV_OC          0
`define RFS_EV_OV          1
`define RFS_EV_SOV         2
`define RFS_EV_UV          3
`define RFS_EV_PG          4
`define RFS_EV_W           5
`define RFS_ST_OC_CORE     0
`define RFS_ST_OC_BR       1
`define RFS_ST_OV          2
`define RFS_ST_SOV         3
`define RFS_ST_UV          4
`define RFS_ST_PG          5
`define RFS_ST_CLAMP       6
`define RFS_ST_FSM         8
`endif

// [logic/rfs_sync.v]
// two-flop synchroniser for asynchronous pins
// assumes pclk domain; bits are independent levels
`timescale 1ns/10ps
module rfs_sync #(
  parameter W = 1
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         ce,
  input  wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);
  // ====================================================================
  // stages
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else if (ce) begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;
endmodule // rfs_sync

// [logic/rfs_uv_qual.v]
// undervoltage qualifier: condition must hold for CYCLES clocks
// assumes below and arm come from pclk logic
`timescale 1ns/10ps
`include "rfs_map.vh"
module rfs_uv_qual #(
  parameter             CNT_W  = `RFS_UV_CNT_W,
  parameter [CNT_W-1:0] CYCLES = `RFS_UV_CYCLES
) (
  input  wire pclk,
  input  wire presetn,
  input  wire ce,
  input  wire arm,
  input  wire below,
  output wire uv_hit
);
  // ====================================================================
  // counter restarts whenever the condition drops
  reg [CNT_W-1:0] cnt_ff;
  reg             hit_ff;
  wire            last = (cnt_ff == CYCLES - {{(CNT_W-1){1'b0}}, 1'b1});

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= {CNT_W{1'b0}};
      hit_ff <= 1'b0;
    end else if (ce) begin
      if (!(arm && below)) begin
        cnt_ff <= {CNT_W{1'b0}};
        hit_ff <= 1'b0;
      end else if (!last) begin
        cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
        hit_ff <= 1'b1;
      end
    end
  end

  assign uv_hit = hit_ff;
endmodule // rfs_uv_qual

// [logic/rfs_supervisor.v]
// fault supervisor for a core and a bridge buck output, with apb slave
// assumes sense codes come from on-chip converters clocked by pclk;
// enable, supply monitor and overvoltage comparators are async pins
//
// How it works
// R1: overcurrent stops both regulators, drivers tri-stated
// R2: overcurrent pulls regulation ok low
// R3: no self restart; enable or supply cycle clears
// R4: overvoltage latches ok low, all switches off
// R5: overvoltage cleared by enable low or supply low
// R6: enable and supply back starts a soft-start
// R7: above 1.8V clamps low side, latches ok low
// R8: clamp holds until below 0.85V, then off
// R9: clamp repeats whenever 1.8V is exceeded again
// R10: severe latch clears only on enable low
// R11: overvoltage watch stays on while enabled
// R12: 295mV below target for 1ms latches undervoltage
// R13: undervoltage turns all drivers off, ok low
// R14: undervoltage path independent of overcurrent path
// R15: core trip when 5x cap voltage exceeds trip/6
// R16: bridge trip when drop exceeds 10uA times resistor
// R17: ok low in shutdown and soft-start until in limits
// R18: ok low while disabled or supply low
// R19: pins synchronised; 1ms counted in clock cycles
`timescale 1ns/10ps
`include "rfs_map.vh"
module rfs_supervisor #(
  parameter                    VW        = 12,
  parameter                    OCW       = 16,
  parameter                    BRW       = 16,
  parameter [`RFS_UV_CNT_W-1:0] UV_CYCLES = `RFS_UV_CYCLES
) (
  input  wire           pclk,
  input  wire           presetn,
  input  wire           ce,
  input  wire           psel,
  input  wire           penable,
  input  wire           pwrite,
  input  wire [7:0]     paddr,
  input  wire [31:0]    pwdata,
  output wire [31:0]    prdata,
  output wire           pready,
  output wire           pslverr,
  output wire           irq,
  input  wire           enable_in,
  input  wire           supply_ok_in,
  input  wire           core_ov_cmp_in,
  input  wire           bridge_ov_cmp_in,
  input  wire [VW-1:0]  core_vout_mv,
  input  wire [VW-1:0]  bridge_vout_mv,
  input  wire [VW-1:0]  core_voltage_code_target,
  input  wire [VW-1:0]  bridge_voltage_code_target,
  input  wire [OCW-1:0] core_cap_sense,
  input  wire [OCW-1:0] core_trip_level_input,
  input  wire [BRW-1:0] bridge_ls_drop_uv,
  input  wire [BRW-1:0] bridge_trip_resistor_pin,
  input  wire [1:0]     pwm_hs_req,
  input  wire [1:0]     pwm_ls_req,
  input  wire           soft_start_done,
  output wire           soft_start_go,
  output wire [1:0]     drv_hs_on,
  output wire [1:0]     drv_ls_on,
  output wire [1:0]     drv_hiz,
  output wire           regulation_ok_out,
  output wire           regulation_ok_oe
);
  // ====================================================================
  // states
  localparam [1:0] ST_OFF   = 2'h0;
  localparam [1:0] ST_SOFT  = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;
  localparam [1:0] ST_FAULT = 2'h3;

  localparam [VW-1:0]  SOV_TRIP = `RFS_SOV_TRIP_MV;
  localparam [VW-1:0]  SOV_REL  = `RFS_SOV_REL_MV;
  localparam [VW:0]    UV_MARG  = `RFS_UV_MARGIN_MV;
  localparam [OCW+2:0] OC_GAIN  = `RFS_OC_GAIN;
  localparam [OCW-1:0] OC_DIV   = `RFS_OC_DIV;
  localparam [BRW+3:0] BR_SRC   = `RFS_BR_SRC_UA;

  // ====================================================================
  // pin synchronisers
  wire [3:0] pin_s;
  rfs_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d_in    ({bridge_ov_cmp_in, core_ov_cmp_in, supply_ok_in,
               enable_in}),
    .q_out   (pin_s)
  ); // see R19

  reg        ctrl_en_ff;
  wire       en_on   = pin_s[0] & ctrl_en_ff;
  wire       sup_on  = pin_s[1];
  wire       chip_on = en_on & sup_on;
  wire [1:0] ov_s    = pin_s[3:2];

  // ====================================================================
  // overcurrent comparisons
  wire [OCW+2:0] core_amp  = {3'h0, core_cap_sense} * OC_GAIN;
  wire [OCW-1:0] core_lim  = core_trip_level_input / OC_DIV;
  wire           core_oc   = core_amp > {3'h0, core_lim}; // see R15
  wire [BRW+3:0] br_lim    = {4'h0, bridge_trip_resistor_pin} * BR_SRC;
  wire           br_oc     = {4'h0, bridge_ls_drop_uv} > br_lim; // see R16

  // ====================================================================
  // per-output voltage watch
  wire [2*VW-1:0] vout = {bridge_vout_mv, core_vout_mv};
  wire [2*VW-1:0] vtgt = {bridge_voltage_code_target,
                          core_voltage_code_target};
  reg  [1:0]      state_ff;
  reg  [1:0]      clamp_ff;
  wire [1:0]      sov_hi;
  wire [1:0]      uv_below;
  wire [1:0]      uv_hit;
  wire            run_st   = (state_ff == ST_RUN);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_out
      wire [VW-1:0] v = vout[gi*VW +: VW];
      wire [VW-1:0] t = vtgt[gi*VW +: VW];
      assign sov_hi[gi]   = v > SOV_TRIP; // see R7
      assign uv_below[gi] = ({1'b0, v} + UV_MARG) < {1'b0, t}; // see R12

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          clamp_ff[gi] <= 1'b0;
        end else if (ce) begin
          if (chip_on && sov_hi[gi]) begin
            clamp_ff[gi] <= 1'b1; // see R9
          end else if (!en_on || v < SOV_REL) begin
            clamp_ff[gi] <= 1'b0; // see R8
          end
        end
      end

      rfs_uv_qual #(.CNT_W(`RFS_UV_CNT_W), .CYCLES(UV_CYCLES)) u_uv (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .arm     (run_st),
        .below   (uv_below[gi]),
        .uv_hit  (uv_hit[gi])
      ); // see R19
    end
  endgenerate

  // ====================================================================
  // fault latches
  reg  oc_core_ff, oc_br_ff, ov_ff, sov_ff, uv_ff;
  reg  nxt_oc_core, nxt_oc_br, nxt_ov, nxt_sov, nxt_uv;
  wire active  = (state_ff == ST_SOFT) || run_st;
  wire any_flt = oc_core_ff | oc_br_ff | ov_ff | sov_ff | uv_ff;

  always @* begin
    nxt_oc_core = oc_core_ff | (active & core_oc);
    nxt_oc_br   = oc_br_ff | (active & br_oc);
    nxt_ov      = ov_ff | (chip_on & (|ov_s)); // see R11
    nxt_sov     = sov_ff | (chip_on & (|sov_hi)); // see R7
    nxt_uv      = uv_ff | (active & (|uv_hit)); // see R14
    if (!sup_on) begin
      nxt_oc_core = 1'b0; // see R3
      nxt_oc_br   = 1'b0;
      nxt_ov      = 1'b0; // see R5
      nxt_uv      = 1'b0;
    end
    if (!en_on) begin
      nxt_oc_core = 1'b0;
      nxt_oc_br   = 1'b0;
      nxt_ov      = 1'b0;
      nxt_sov     = 1'b0; // see R10
      nxt_uv      = 1'b0;
    end
  end

  // ====================================================================
  // sequencer
  reg [1:0] nxt_state;
  reg       go_ff;
  wire      in_limits = ~(|sov_hi) & ~(|ov_s) & ~(|uv_below);

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF: begin
        if (chip_on && !any_flt) begin
          nxt_state = ST_SOFT; // see R6
        end
      end
      ST_SOFT: begin
        if (!chip_on) begin
          nxt_state = ST_OFF;
        end else if (any_flt) begin
          nxt_state = ST_FAULT;
        end else if (soft_start_done && in_limits) begin
          nxt_state = ST_RUN; // see R17
        end
      end
      ST_RUN: begin
        if (!chip_on) begin
          nxt_state = ST_OFF;
        end else if (any_flt) begin
          nxt_state = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (!any_flt) begin
          nxt_state = ST_OFF; // see R3
        end
      end
      default: nxt_state = ST_OFF;
    endcase
  end

  // ====================================================================
  // driver and regulation ok outputs
  reg [1:0] hs_ff, ls_ff, hiz_ff;
  reg [1:0] nxt_hs, nxt_ls, nxt_hiz;
  reg       pg_ff;
  wire      oc_any  = oc_core_ff | oc_br_ff;
  wire      nxt_pg  = run_st & chip_on & ~any_flt; // see R18
  integer   k;

  always @* begin
    nxt_hs  = 2'h0;
    nxt_ls  = 2'h0;
    nxt_hiz = 2'h0;
    for (k = 0; k < 2; k = k + 1) begin
      if (clamp_ff[k]) begin
        nxt_ls[k] = 1'b1; // see R7
      end else if (oc_any) begin
        nxt_hiz[k] = 1'b1; // see R1
      end else if (active && chip_on && !any_flt) begin
        nxt_hs[k] = pwm_hs_req[k];
        nxt_ls[k] = pwm_ls_req[k] & ~pwm_hs_req[k];
      end
    end
  end // ov, severe and uv latches fall through to all off: see R4 R13

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= ST_OFF;
      go_ff      <= 1'b0;
      oc_core_ff <= 1'b0;
      oc_br_ff   <= 1'b0;
      ov_ff      <= 1'b0;
      sov_ff     <= 1'b0;
      uv_ff      <= 1'b0;
      hs_ff      <= 2'h0;
      ls_ff      <= 2'h0;
      hiz_ff     <= 2'h0;
      pg_ff      <= 1'b0;
    end else if (ce) begin
      state_ff   <= nxt_state;
      go_ff      <= (state_ff == ST_OFF) && (nxt_state == ST_SOFT);
      oc_core_ff <= nxt_oc_core;
      oc_br_ff   <= nxt_oc_br;
      ov_ff      <= nxt_ov;
      sov_ff     <= nxt_sov;
      uv_ff      <= nxt_uv;
      hs_ff      <= nxt_hs;
      ls_ff      <= nxt_ls;
      hiz_ff     <= nxt_hiz;
      pg_ff      <= nxt_pg; // see R2 R17
    end
  end

  assign soft_start_go     = go_ff;
  assign drv_hs_on         = hs_ff;
  assign drv_ls_on         = ls_ff;
  assign drv_hiz           = hiz_ff;
  assign regulation_ok_out = 1'b0;
  assign regulation_ok_oe  = ~pg_ff;

  // ====================================================================
  // interrupt events
  reg  [`RFS_EV_W-1:0] int_stat_ff;
  reg  [`RFS_EV_W-1:0] int_en_ff;
  reg  [`RFS_EV_W-1:0] ev;
  reg  [`RFS_EV_W-1:0] clr;

  always @* begin
    ev = {`RFS_EV_W{1'b0}};
    ev[`RFS_EV_OC]  = (nxt_oc_core | nxt_oc_br) & ~oc_any;
    ev[`RFS_EV_OV]  = nxt_ov & ~ov_ff;
    ev[`RFS_EV_SOV] = nxt_sov & ~sov_ff;
    ev[`RFS_EV_UV]  = nxt_uv & ~uv_ff;
    ev[`RFS_EV_PG]  = pg_ff & ~nxt_pg;
  end

  assign irq = |(int_stat_ff & int_en_ff);

  // ====================================================================
  // apb slave, zero wait while clock enable is high
  wire acc    = psel & penable & ce;
  wire wr     = acc & pwrite;
  wire setup  = psel & ~penable & ~pwrite & ce;
  wire hit    = (paddr == `RFS_A_CTRL) || (paddr == `RFS_A_STATUS) ||
                (paddr == `RFS_A_INT_STAT) || (paddr == `RFS_A_INT_EN) ||
                (paddr == `RFS_A_INT_CLR);
  reg  [31:0] rd_ff;
  reg  [31:0] nxt_rd;
  reg  [31:0] status;

  always @* begin
    clr = {`RFS_EV_W{1'b0}};
    if (wr && paddr == `RFS_A_INT_CLR) begin
      clr = pwdata[`RFS_EV_W-1:0];
    end
  end

  always @* begin
    status = 32'h0000_0000;
    status[`RFS_ST_OC_CORE]      = oc_core_ff;
    status[`RFS_ST_OC_BR]        = oc_br_ff;
    status[`RFS_ST_OV]           = ov_ff;
    status[`RFS_ST_SOV]          = sov_ff;
    status[`RFS_ST_UV]           = uv_ff;
    status[`RFS_ST_PG]           = pg_ff;
    status[`RFS_ST_CLAMP +: 2]   = clamp_ff;
    status[`RFS_ST_FSM +: 2]     = state_ff;
    nxt_rd = 32'h0000_0000;
    case (paddr)
      `RFS_A_CTRL:     nxt_rd[`RFS_CTRL_EN] = ctrl_en_ff;
      `RFS_A_STATUS:   nxt_rd = status;
      `RFS_A_INT_STAT: nxt_rd[`RFS_EV_W-1:0] = int_stat_ff;
      `RFS_A_INT_EN:   nxt_rd[`RFS_EV_W-1:0] = int_en_ff;
      default:         nxt_rd = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_ff  <= `RFS_CTRL_RST;
      int_en_ff   <= {`RFS_EV_W{1'b0}};
      int_stat_ff <= {`RFS_EV_W{1'b0}};
      rd_ff       <= 32'h0000_0000;
    end else if (ce) begin
      int_stat_ff <= (int_stat_ff & ~clr) | ev;
      if (setup) begin
        rd_ff <= nxt_rd;
      end
      if (wr && paddr == `RFS_A_CTRL) begin
        ctrl_en_ff <= pwdata[`RFS_CTRL_EN];
      end
      if (wr && paddr == `RFS_A_INT_EN) begin
        int_en_ff <= pwdata[`RFS_EV_W-1:0];
      end
    end
  end

  assign pready  = ce;
  assign pslverr = acc & ~hit;
  assign prdata  = rd_ff;
endmodule // rfs_supervisor

// [dv/rfs_supervisor_sva.sv]
// checker for rfs_supervisor driver and ok-pin relations
// assumes one pclk domain; bound onto every rfs_supervisor
`timescale 1ns/10ps
module rfs_supervisor_sva #(
  parameter VW = 12
) (
  input wire          pclk,
  input wire          presetn,
  input wire          enable_in,
  input wire          supply_ok_in,
  input wire [VW-1:0] core_vout_mv,
  input wire [1:0]    pwm_ls_req,
  input wire          soft_start_go,
  input wire [1:0]    drv_hs_on,
  input wire [1:0]    drv_ls_on,
  input wire [1:0]    drv_hiz,
  input wire          regulation_ok_oe
);
  // ==========================================================
  // properties
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_excl; !(|(drv_hs_on & drv_ls_on)); endproperty
  a_excl: assert property (p_excl)
    else $error("high and low side on together");
  property p_dis; !enable_in [*7] |->
    !(|{drv_hs_on, drv_ls_on, drv_hiz}) && regulation_ok_oe; endproperty
  a_dis: assert property (p_dis)
    else $error("drivers active while disabled");
  property p_sup; !supply_ok_in [*7] |-> regulation_ok_oe; endproperty
  a_sup: assert property (p_sup)
    else $error("ok released with supply low");
  property p_sov; (enable_in && supply_ok_in) [*5] ##0
    (core_vout_mv > 1800) |-> ##2
    (drv_ls_on[0] && !drv_hs_on[0] && regulation_ok_oe); endproperty
  a_sov: assert property (p_sov)
    else $error("no low side clamp above severe level");
  property p_hold; drv_ls_on[0] && !$past(pwm_ls_req[0]) &&
    $past(core_vout_mv) >= 850 && $past(enable_in) &&
    $past(enable_in, 2) && $past(enable_in, 3) |=> drv_ls_on[0];
  endproperty
  a_hold: assert property (p_hold)
    else $error("clamp released above release level");
  property p_oef; |drv_hiz |-> regulation_ok_oe; endproperty
  a_oef: assert property (p_oef)
    else $error("ok released during overcurrent");
  property p_both; |drv_hiz |-> (drv_hiz | drv_ls_on) == 2'h3; endproperty
  a_both: assert property (p_both)
    else $error("only one output shut down");
  property p_norst; (enable_in && supply_ok_in) [*6] ##0 (|drv_hiz)
    |=> |(drv_hiz | drv_ls_on); endproperty
  a_norst: assert property (p_norst)
    else $error("overcurrent shutdown left on its own");
  property p_go; soft_start_go |-> regulation_ok_oe &&
    $past(enable_in, 3) && $past(supply_ok_in, 3); endproperty
  a_go: assert property (p_go)
    else $error("soft start without enable and supply");
endmodule // rfs_supervisor_sva
bind rfs_supervisor rfs_supervisor_sva #(.VW(VW)) u_rfs_supervisor_sva (
  .pclk, .presetn, .enable_in, .supply_ok_in, .core_vout_mv, .pwm_ls_req,
  .soft_start_go, .drv_hs_on, .drv_ls_on, .drv_hiz, .regulation_ok_oe);

// [dv/rfs_ok_monitor.sv]
// external monitor on the open-drain regulation ok wire
// assumes a pull-up; oe high means the pin is pulled low
`timescale 1ns/10ps
module rfs_ok_monitor (
  input  wire ok_out,
  input  wire ok_oe,
  output wire ok_wire
);
  // ==========================================================
  // wire level: pull-up wins while the pin is released
  assign ok_wire = ok_oe ? ok_out : 1'b1;
endmodule // rfs_ok_monitor

// [dv/rfs_supervisor_tb.sv]
// testbench for rfs_supervisor: apb registers, fault pins, ok wire
// assumes rfs_map.vh on the include path, checker bound by its file
`timescale 1ns/10ps
`include "rfs_map.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  n_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module rfs_supervisor_tb;
  // ==========================================================
  // signals
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        irq, en, sup, cov, bov, ssd, ssg, ok_out, ok_oe, ok_wire;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] cv, bv, ctg, btg;
  logic [15:0] cap, trip, drop, rtr;
  logic [1:0]  hs, ls, dhs, dls, dhz, r;
  logic [32:0] exp_v;
  logic [32:0] exp_q[$];
  int          n_errors, check_count;
  rfs_supervisor #(.UV_CYCLES(18'd20)) u_rfs_supervisor (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .enable_in(en), .supply_ok_in(sup), .core_ov_cmp_in(cov),
    .bridge_ov_cmp_in(bov), .core_vout_mv(cv), .bridge_vout_mv(bv),
    .core_voltage_code_target(ctg), .bridge_voltage_code_target(btg),
    .core_cap_sense(cap), .core_trip_level_input(trip),
    .bridge_ls_drop_uv(drop), .bridge_trip_resistor_pin(rtr),
    .pwm_hs_req(hs), .pwm_ls_req(ls), .soft_start_done(ssd),
    .soft_start_go(ssg), .drv_hs_on(dhs), .drv_ls_on(dls), .drv_hiz(dhz),
    .regulation_ok_out(ok_out), .regulation_ok_oe(ok_oe));
  rfs_ok_monitor u_rfs_ok_monitor (
    .ok_out(ok_out), .ok_oe(ok_oe), .ok_wire(ok_wire));
  // ==========================================================
  // clock, tasks, read monitor
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wi(input logic [7:0] a, input logic [31:0] d,
                    input logic e);
    apb(1'b1, a, d);
    w(1);
    `CHK(irq, e)
  endtask
  task automatic up();
    int k;
    ssd <= 1'b0;
    en <= 1'b1;
    sup <= 1'b1;
    k = 0;
    while (ssg !== 1'b1 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    `CHK(ssg, 1'b1)
    w(6);
    `CHK(ok_wire, 1'b0)
    ssd <= 1'b1;
    w(6);
    `CHK(ok_wire, 1'b1)
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    if ((psel && penable && pready && !pwrite) === 1'b1) begin
      exp_v = exp_q.size() ? exp_q.pop_front() : 33'h0;
      `CHK({pslverr, prdata}, exp_v)
    end
  end
  initial begin
    #20000;
    n_errors++;
    $display("[FAIL] %0t watchdog", $time);
    results();
  end
  // ==========================================================
  // tests
  initial begin
    void'($urandom(32'hbfb465d5));
    {presetn, ce, psel, penable, pwrite, en, sup, cov, bov, ssd} = 10'h100;
    {paddr, pwdata} = '0;
    {cv, bv, ctg, btg} = {4{12'd1000}};
    {cap, trip, drop, rtr} = {16'd0, 16'd600, 16'd0, 16'd100};
    {hs, ls} = 4'hc;
    w(2);
    presetn <= 1'b1;
    rd(`RFS_A_STATUS, 33'h0);
    rd(`RFS_A_CTRL, 33'h1);
    rd(`RFS_A_INT_EN, 33'h0);
    rd(`RFS_A_INT_CLR, 33'h0);
    rd(8'h14, 33'h100000000);
    $display("test regs done");
    up();
    for (int i = 0; i < 8; i++) begin
      r = 2'($urandom);
      hs <= r;
      ls <= ~r;
      w(3);
      `CHK({dhs, dls}, {r, ~r})
    end
    ce <= 1'b0;
    hs <= ~r;
    w(4);
    `CHK({pready, dhs, dls}, {1'b0, r, ~r})
    ce <= 1'b1;
    hs <= 2'h3;
    ls <= 2'h0;
    $display("test power done");
    apb(1'b1, `RFS_A_INT_EN, 32'h1f);
    cap <= 16'd20;
    w(8);
    `CHK({dhz, dhs}, 4'h3)
    cap <= 16'd21;
    w(8);
    `CHK({dhz, dhs, dls, ok_wire}, 7'h60)
    `CHK(irq, 1'b1)
    rd(`RFS_A_STATUS, 33'h301);
    rd(`RFS_A_INT_STAT, 33'h11);
    cap <= 16'd0;
    w(20);
    `CHK(dhz, 2'h3)
    wi(`RFS_A_INT_EN, 32'h0, 1'b0);
    wi(`RFS_A_INT_EN, 32'h1f, 1'b1);
    wi(`RFS_A_INT_CLR, 32'h1f, 1'b0);
    en <= 1'b0;
    w(8);
    `CHK(ok_wire, 1'b0)
    up();
    `CHK(dhz, 2'h0)
    drop <= 16'd1000;
    w(8);
    `CHK(dhz, 2'h0)
    drop <= 16'd1001;
    w(8);
    `CHK(dhz, 2'h3)
    rd(`RFS_A_STATUS, 33'h302);
    drop <= 16'd0;
    sup <= 1'b0;
    w(8);
    up();
    `CHK(dhz, 2'h0)
    $display("test overcurrent done");
    bov <= 1'b1;
    w(8);
    bov <= 1'b0;
    `CHK({dhz, dhs, dls, ok_wire}, 7'h0)
    w(8);
    `CHK({dhz, dhs, dls, ok_wire}, 7'h0)
    rd(`RFS_A_STATUS, 33'h304);
    sup <= 1'b0;
    w(8);
    up();
    $display("test overvoltage done");
    cv <= 12'd1800;
    w(8);
    `CHK({dls, ok_wire}, 3'h1)
    cv <= 12'd1801;
    w(4);
    `CHK({dhs, dls, ok_wire}, 5'h2)
    cv <= 12'd850;
    w(8);
    `CHK(dls, 2'h1)
    cv <= 12'd849;
    w(4);
    `CHK(dls, 2'h0)
    cv <= 12'd1801;
    w(4);
    `CHK(dls, 2'h1)
    cv <= 12'd849;
    sup <= 1'b0;
    w(8);
    sup <= 1'b1;
    w(12);
    `CHK({dls, ok_wire}, 3'h0)
    en <= 1'b0;
    cv <= 12'd1000;
    w(8);
    up();
    $display("test severe done");
    cv <= 12'd700;
    w(10);
    cv <= 12'd1000;
    w(4);
    cv <= 12'd700;
    `CHK(dhs, 2'h3)
    w(14);
    `CHK(dhs, 2'h3)
    w(12);
    `CHK({dhz, dhs, dls, ok_wire}, 7'h0)
    rd(`RFS_A_STATUS, 33'h310);
    $display("test undervoltage done");
    w(2);
    results();
  end
endmodule // rfs_supervisor_tb
